// *** design/tcp_pkg.sv ***
// Purpose: Shared constants for the timer compare and pulse unit.
// Assumes: Byte-wide registers, one per aligned 32-bit Wishbone word.
// Notes: Offsets are byte addresses on the register bus.
package tcp_pkg;

  // Register byte offsets
  localparam logic [4:0] TCP_OFF_CTRL_ONE = 5'h00;
  localparam logic [4:0] TCP_OFF_CTRL_TWO = 5'h04;
  localparam logic [4:0] TCP_OFF_STATUS = 5'h08;
  localparam logic [4:0] TCP_OFF_CMP1_HI = 5'h0c;
  localparam logic [4:0] TCP_OFF_CMP1_LO = 5'h10;
  localparam logic [4:0] TCP_OFF_CMP2_HI = 5'h14;
  localparam logic [4:0] TCP_OFF_CMP2_LO = 5'h18;

  // First control register fields
  localparam int TCP_C1_CAP_IE = 7;
  localparam int TCP_C1_CMP_IE = 6;
  localparam int TCP_C1_OVF_IE = 5;
  localparam int TCP_C1_FORCE_TWO = 4;
  localparam int TCP_C1_FORCE_ONE = 3;
  localparam int TCP_C1_LVL_SECOND = 2;
  localparam int TCP_C1_CAP_EDGE_ONE = 1;
  localparam int TCP_C1_LVL_FIRST = 0;

  // Second control register fields
  localparam int TCP_C2_PIN_EN_ONE = 7;
  localparam int TCP_C2_PIN_EN_TWO = 6;
  localparam int TCP_C2_ONE_PULSE = 5;
  localparam int TCP_C2_PWM = 4;
  localparam int TCP_C2_CLK_SEL_HI = 3;
  localparam int TCP_C2_CLK_SEL_LO = 2;
  localparam int TCP_C2_CAP_EDGE_TWO = 1;
  localparam int TCP_C2_EXT_EDGE = 0;

  // Status register fields
  localparam int TCP_SR_CAP_ONE = 7;
  localparam int TCP_SR_CMP_ONE = 6;
  localparam int TCP_SR_OVF = 5;
  localparam int TCP_SR_CAP_TWO = 4;
  localparam int TCP_SR_CMP_TWO = 3;

  // Reset values
  localparam logic [15:0] TCP_CMP_RESET = 16'h8000;
  localparam logic [7:0] TCP_CTRL_RESET = 8'h00;

  // Clock select encodings
  localparam logic [1:0] TCP_CLK_DIV4 = 2'h0;
  localparam logic [1:0] TCP_CLK_DIV2 = 2'h1;
  localparam logic [1:0] TCP_CLK_DIV8 = 2'h2;
  localparam logic [1:0] TCP_CLK_EXT = 2'h3;

  // Prescaler terminal counts, in CPU cycles minus one
  localparam logic [2:0] TCP_DIV2_LAST = 3'h1;
  localparam logic [2:0] TCP_DIV4_LAST = 3'h3;
  localparam logic [2:0] TCP_DIV8_LAST = 3'h7;

endpackage : tcp_pkg

// *** design/tcp_tick_gen.sv ***
// Purpose: Timer clock enable from the CPU clock prescaler or external pin.
// Assumes: External clock is at most a quarter of the CPU clock.
// Notes: Emits a one-cycle tick per timer clock period.
`timescale 1ns/10ps
module tcp_tick_gen
  import tcp_pkg::*;
(
  input wire logic clk,             // CPU clock
  input wire logic rst_n,           // Synchronous reset, active low
  input wire logic [1:0] clk_sel,   // Timer clock select
  input wire logic ext_edge_rise,   // External clock active edge is rising
  input wire logic ext_clk,         // External clock pin, asynchronous
  output logic tick                 // Timer clock enable pulse
);

  logic [2:0] pre_cnt;
  logic [2:0] next_pre_cnt;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic [2:0] last;
  logic pre_tick;
  logic ext_tick;

  always_comb begin
    case (clk_sel)
      TCP_CLK_DIV2: last = TCP_DIV2_LAST;
      TCP_CLK_DIV8: last = TCP_DIV8_LAST;
      default: last = TCP_DIV4_LAST;
    endcase
    pre_tick = (pre_cnt >= last);
    next_pre_cnt = pre_tick ? 3'h0 : pre_cnt + 3'h1;
    ext_tick = ext_edge_rise ? (ext_sync & ~ext_prev)
                             : (~ext_sync & ext_prev);
    tick = (clk_sel == TCP_CLK_EXT) ? ext_tick : pre_tick;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_cnt <= 3'h0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      ext_meta <= ext_clk;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

endmodule : tcp_tick_gen

// *** design/tcp_compare_unit.sv ***
// Purpose: Output compare, forced output, one-pulse and PWM for a timer.
// Assumes: Counter, capture and overflow logic live outside this block.
// Notes: Wishbone classic slave, byte registers in bits 7:0 of each word.
`timescale 1ns/10ps
// Behaviour
// - Both compare values are checked against the counter each timer tick.
// - Compare values are software read/write only, reset to 8000h.
// - A match sets its flag and drives its level when the pin is enabled.
// - Compare pin latches reset low and stay low until a match, a force or a one-pulse trigger raises them.
// - Compare interrupt needs its enable set and the CPU mask clear.
// - Flag clears after status read with flag set, then low byte access.
// - High byte write suspends that channel until its low byte is written.
// - Pin not enabled: no level driven, but interrupt still possible.
// - Divide-by-2 clock: update while counter equals the compare value.
// - Divide by 4, 8 or external: update while counter equals value plus one.
// - Control one: capture, compare, overflow enables at bits 7..5, reset 0.
// - Force bits 4 and 3 copy each channel's level bit to its pin.
// - Forcing sets no flag, no interrupt; pin follows the level bit.
// - One-pulse: capture edge preloads counter, pin one takes second level.
// - One-pulse: flag one never set; flag two and capture flag still work.
// - PWM and one-pulse both set means PWM only.
// - PWM: match one gives first level, match two second level plus preload.
// - PWM: capture flag one sets on match two; capture channel one unused.
// - PWM: neither compare flag is set, so no compare interrupt.
// - Interrupt whenever an enabled compare, capture or overflow flag is set and the CPU mask is clear.
// - Clock select 00 div4, 01 div2, 10 div8, 11 external clock.
// - Status shows compare flag one at bit 6 and two at bit 3.
// - Level second at bit 2, first at bit 0; second feeds pin one in modes.
// - Control two: pin enables at 7 and 6, one-pulse 5, PWM 4.
module tcp_compare_unit
  import tcp_pkg::*;
(
  input wire logic clk,               // CPU clock, 100 MHz
  input wire logic rst_n,             // Synchronous reset, active low
  input wire logic wb_cyc_i,          // Wishbone cycle
  input wire logic wb_stb_i,          // Wishbone strobe
  input wire logic wb_we_i,           // Wishbone write enable
  input wire logic [4:0] wb_adr_i,    // Wishbone byte address
  input wire logic [3:0] wb_sel_i,    // Wishbone byte selects
  input wire logic [31:0] wb_dat_i,   // Wishbone write data
  output logic [31:0] wb_dat_o,       // Wishbone read data
  output logic wb_ack_o,              // Wishbone acknowledge
  input wire logic [15:0] counter_value, // Free-running counter
  input wire logic capture_input_one, // Capture pin one, asynchronous
  input wire logic ext_clk,           // External timer clock pin
  input wire logic capture_flag_one,  // Capture flag one from capture logic
  input wire logic capture_flag_two,  // Capture flag two from capture logic
  input wire logic overflow_flag,     // Overflow flag from counter logic
  input wire logic cpu_int_mask,      // CPU global interrupt mask bit
  output logic timer_tick,            // Timer clock enable pulse
  output logic [1:0] clock_select,    // Timer clock select to counter
  output logic counter_preload,       // Pulse: load counter with FFFCh
  output logic capture_one_set,       // Pulse: set capture flag one
  output logic overflow_irq_enable,   // Overflow enable to counter logic
  output logic capture_edge_one,      // Capture one edge select
  output logic capture_edge_two,      // Capture two edge select
  output logic compare_output_pin_one, // Compare pin one level
  output logic compare_pin_one_oe_n,  // Pin one driven when low
  output logic compare_output_pin_two, // Compare pin two level
  output logic compare_pin_two_oe_n,  // Pin two driven when low
  output logic timer_irq              // Timer interrupt request, level
);

  function automatic logic cmp_hit(input logic [15:0] cnt,
                                   input logic [15:0] cmp,
                                   input logic plus_one);
    logic [15:0] target;
    target = plus_one ? 16'(cmp + 16'h0001) : cmp;
    cmp_hit = (cnt == target);
  endfunction : cmp_hit

  // Register state
  logic [7:0] timer_control_one;
  logic [7:0] timer_control_two;
  logic [15:0] compare_value_one;
  logic [15:0] compare_value_two;
  logic compare_flag_one;
  logic compare_flag_two;
  logic [1:0] inhibit;
  logic [1:0] clr_armed;
  logic pin_one;
  logic pin_two;
  logic cap_meta;
  logic cap_sync;
  logic cap_prev;
  logic cap_pend;
  logic [31:0] rd_data;
  logic ack;
  logic irq;

  logic [7:0] next_control_one;
  logic [7:0] next_control_two;
  logic [15:0] next_cmp_one;
  logic [15:0] next_cmp_two;
  logic next_flag_one;
  logic next_flag_two;
  logic [1:0] next_inhibit;
  logic [1:0] next_clr_armed;
  logic next_pin_one;
  logic next_pin_two;
  logic next_cap_pend;
  logic [31:0] next_rd_data;
  logic next_ack;
  logic next_irq;

  // Bus decode
  logic req;
  logic take;
  logic wr_lane;
  logic rd_status;
  logic acc_lo_one;
  logic acc_lo_two;
  logic [7:0] status;
  logic [7:0] wbyte;

  // Mode and match terms
  logic pin_en_one;
  logic pin_en_two;
  logic pwm_mode;
  logic pulse_mode;
  logic plus_one;
  logic match_one;
  logic match_two;
  logic cap_edge;
  logic cap_fire;
  logic lvl_first;
  logic lvl_second;
  logic force_one;
  logic force_two;

  tcp_tick_gen u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .clk_sel(clock_select),
    .ext_edge_rise(timer_control_two[TCP_C2_EXT_EDGE]),
    .ext_clk(ext_clk),
    .tick(timer_tick)
  );

  always_comb begin
    clock_select = timer_control_two[TCP_C2_CLK_SEL_HI:TCP_C2_CLK_SEL_LO];
    pin_en_one = timer_control_two[TCP_C2_PIN_EN_ONE];
    pin_en_two = timer_control_two[TCP_C2_PIN_EN_TWO];
    pwm_mode = timer_control_two[TCP_C2_PWM];
    pulse_mode = timer_control_two[TCP_C2_ONE_PULSE] & ~pwm_mode;
    lvl_first = timer_control_one[TCP_C1_LVL_FIRST];
    lvl_second = timer_control_one[TCP_C1_LVL_SECOND];
    force_one = timer_control_one[TCP_C1_FORCE_ONE];
    force_two = timer_control_one[TCP_C1_FORCE_TWO];
    // Only the divide-by-2 clock sees the match on the exact count
    plus_one = (clock_select != TCP_CLK_DIV2);
    // A pending high byte write blocks the channel until the low byte
    match_one = timer_tick & ~inhibit[0]
              & cmp_hit(counter_value, compare_value_one, plus_one);
    match_two = timer_tick & ~inhibit[1]
              & cmp_hit(counter_value, compare_value_two, plus_one);
    cap_edge = timer_control_one[TCP_C1_CAP_EDGE_ONE]
             ? (cap_sync & ~cap_prev) : (~cap_sync & cap_prev);
    // Edges between ticks wait so the preload lines up with a count
    next_cap_pend = pulse_mode & ~timer_tick & (cap_edge | cap_pend);
    cap_fire = pulse_mode & timer_tick & (cap_edge | cap_pend);
    counter_preload = (pwm_mode & match_two)
                    | cap_fire;
    capture_one_set = pwm_mode & match_two;
    overflow_irq_enable = timer_control_one[TCP_C1_OVF_IE];
    capture_edge_one = timer_control_one[TCP_C1_CAP_EDGE_ONE];
    capture_edge_two = timer_control_two[TCP_C2_CAP_EDGE_TWO];
  end

  always_comb begin
    req = wb_cyc_i & wb_stb_i;
    // Effects land on the edge where the master sees ack high
    take = req & ack;
    wr_lane = take & wb_we_i & wb_sel_i[0];
    wbyte = wb_dat_i[7:0];
    rd_status = take & ~wb_we_i & (wb_adr_i == TCP_OFF_STATUS);
    acc_lo_one = take & (wb_adr_i == TCP_OFF_CMP1_LO);
    acc_lo_two = take & (wb_adr_i == TCP_OFF_CMP2_LO);
    status = 8'h00;
    status[TCP_SR_CAP_ONE] = capture_flag_one;
    status[TCP_SR_CMP_ONE] = compare_flag_one;
    status[TCP_SR_OVF] = overflow_flag;
    status[TCP_SR_CAP_TWO] = capture_flag_two;
    status[TCP_SR_CMP_TWO] = compare_flag_two;
  end

  // Register file
  always_comb begin
    next_control_one = timer_control_one;
    next_control_two = timer_control_two;
    next_cmp_one = compare_value_one;
    next_cmp_two = compare_value_two;
    next_inhibit = inhibit;
    next_ack = req & ~ack;
    next_rd_data = 32'h0000_0000;
    if (req & ~ack & ~wb_we_i) begin
      // Reads have no side effect beyond the flag clearing sequence
      case (wb_adr_i)
        TCP_OFF_CTRL_ONE: next_rd_data[7:0] = timer_control_one;
        TCP_OFF_CTRL_TWO: next_rd_data[7:0] = timer_control_two;
        TCP_OFF_STATUS: next_rd_data[7:0] = status;
        TCP_OFF_CMP1_HI: next_rd_data[7:0] = compare_value_one[15:8];
        TCP_OFF_CMP1_LO: next_rd_data[7:0] = compare_value_one[7:0];
        TCP_OFF_CMP2_HI: next_rd_data[7:0] = compare_value_two[15:8];
        TCP_OFF_CMP2_LO: next_rd_data[7:0] = compare_value_two[7:0];
        default: next_rd_data = 32'h0000_0000;
      endcase
    end
    if (wr_lane) begin
      case (wb_adr_i)
        TCP_OFF_CTRL_ONE: next_control_one = wbyte;
        TCP_OFF_CTRL_TWO: next_control_two = wbyte;
        TCP_OFF_CMP1_HI: begin
          next_cmp_one[15:8] = wbyte;
          next_inhibit[0] = 1'b1;
        end
        TCP_OFF_CMP1_LO: begin
          next_cmp_one[7:0] = wbyte;
          next_inhibit[0] = 1'b0;
        end
        TCP_OFF_CMP2_HI: begin
          next_cmp_two[15:8] = wbyte;
          next_inhibit[1] = 1'b1;
        end
        TCP_OFF_CMP2_LO: begin
          next_cmp_two[7:0] = wbyte;
          next_inhibit[1] = 1'b0;
        end
        default: next_inhibit = inhibit;
      endcase
    end
  end

  // Compare flags and their two-step clear
  always_comb begin
    next_clr_armed = clr_armed;
    next_flag_one = compare_flag_one;
    next_flag_two = compare_flag_two;
    if (rd_status) begin
      next_clr_armed[0] = compare_flag_one;
      next_clr_armed[1] = compare_flag_two;
    end
    if (acc_lo_one) begin
      next_clr_armed[0] = 1'b0;
      if (clr_armed[0]) begin
        next_flag_one = 1'b0;
      end
    end
    if (acc_lo_two) begin
      next_clr_armed[1] = 1'b0;
      if (clr_armed[1]) begin
        next_flag_two = 1'b0;
      end
    end
    // Set wins over a clear in the same cycle; forcing never sets a flag
    if (match_one & ~pwm_mode & ~pulse_mode) begin
      next_flag_one = 1'b1;
    end
    if (match_two & ~pwm_mode) begin
      next_flag_two = 1'b1;
    end
  end

  // Compare pin latches
  always_comb begin
    next_pin_one = pin_one;
    next_pin_two = pin_two;
    if (pwm_mode) begin
      if (match_one) begin
        next_pin_one = lvl_first;
      end
      // Period end wins if both matches land on one tick
      if (match_two) begin
        next_pin_one = lvl_second;
      end
    end else if (pulse_mode) begin
      if (match_one) begin
        next_pin_one = lvl_first;
      end
      if (cap_fire) begin
        next_pin_one = lvl_second;
      end
    end else if (match_one & pin_en_one) begin
      next_pin_one = lvl_first;
    end
    if (match_two & pin_en_two) begin
      next_pin_two = lvl_second;
    end
    // Forced output tracks the level bit every cycle
    if (force_one) begin
      next_pin_one = lvl_first;
    end
    if (force_two) begin
      next_pin_two = lvl_second;
    end
  end

  // Interrupt request, registered so the output never glitches
  always_comb begin
    next_irq = ~cpu_int_mask & (
        (timer_control_one[TCP_C1_CMP_IE]
          & (compare_flag_one | compare_flag_two))
      | (timer_control_one[TCP_C1_CAP_IE]
          & (capture_flag_one | capture_flag_two))
      | (timer_control_one[TCP_C1_OVF_IE] & overflow_flag));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_control_one <= TCP_CTRL_RESET;
      timer_control_two <= TCP_CTRL_RESET;
      compare_value_one <= TCP_CMP_RESET;
      compare_value_two <= TCP_CMP_RESET;
      compare_flag_one <= 1'b0;
      compare_flag_two <= 1'b0;
      inhibit <= 2'h0;
      clr_armed <= 2'h0;
      pin_one <= 1'b0;
      pin_two <= 1'b0;
      cap_meta <= 1'b0;
      cap_sync <= 1'b0;
      cap_prev <= 1'b0;
      cap_pend <= 1'b0;
      rd_data <= 32'h0000_0000;
      ack <= 1'b0;
      irq <= 1'b0;
    end else begin
      timer_control_one <= next_control_one;
      timer_control_two <= next_control_two;
      compare_value_one <= next_cmp_one;
      compare_value_two <= next_cmp_two;
      compare_flag_one <= next_flag_one;
      compare_flag_two <= next_flag_two;
      inhibit <= next_inhibit;
      clr_armed <= next_clr_armed;
      pin_one <= next_pin_one;
      pin_two <= next_pin_two;
      cap_meta <= capture_input_one;
      cap_sync <= cap_meta;
      cap_prev <= cap_sync;
      cap_pend <= next_cap_pend;
      rd_data <= next_rd_data;
      ack <= next_ack;
      irq <= next_irq;
    end
  end

  always_comb begin
    wb_dat_o = rd_data;
    wb_ack_o = ack;
    timer_irq = irq;
    compare_output_pin_one = pin_one;
    compare_output_pin_two = pin_two;
    // Without pin enable the pin stays general I/O and is not driven
    compare_pin_one_oe_n = ~pin_en_one;
    compare_pin_two_oe_n = ~pin_en_two;
  end

endmodule : tcp_compare_unit

// *** sim/tcp_compare_unit_assertions.sv ***
// Purpose: Port-level timing checks for the compare unit
// Assumes: Sees only the top-level ports of tcp_compare_unit
// Notes: Bound into every instance by the bind at the foot
`timescale 1ns/10ps
module tcp_compare_chk
  import tcp_pkg::*;
(
  input wire logic clk, // CPU clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic cpu_int_mask, // CPU mask bit
  input wire logic timer_tick, // Timer clock enable
  input wire logic counter_preload, // Counter load pulse
  input wire logic capture_one_set, // Capture flag one set pulse
  input wire logic compare_output_pin_one, // Pin one latch
  input wire logic timer_irq // Interrupt request
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_ack_latency: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_dat_upper: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_irq_masked: assert property (cpu_int_mask ##1 cpu_int_mask |-> !timer_irq)
    else $error("interrupt raised while masked");
  a_tick_gap: assert property (timer_tick |=> !timer_tick)
    else $error("ticks closer than two cycles");
  a_preload_tick: assert property (counter_preload |-> timer_tick)
    else $error("preload outside a tick");
  a_capset_pair: assert property (capture_one_set |-> counter_preload)
    else $error("capture set without period match");
  // A pin moves only after a compare tick or a control write
  a_pin_cause: assert property ($changed(compare_output_pin_one) |->
    $past(timer_tick, 1) || $past(timer_tick, 2) || $past(wb_ack_o, 1) ||
    $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("pin one changed without cause");
endmodule : tcp_compare_chk

bind tcp_compare_unit tcp_compare_chk tcp_compare_chk_i (
  .clk(clk),
  .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .cpu_int_mask(cpu_int_mask),
  .timer_tick(timer_tick),
  .counter_preload(counter_preload),
  .capture_one_set(capture_one_set),
  .compare_output_pin_one(compare_output_pin_one),
  .timer_irq(timer_irq)
);

// *** sim/tcp_counter_model.sv ***
// Purpose: Free-running counter standing beside the compare unit
// Assumes: Counts only on timer ticks from the unit
// Notes: Preload wins over counting in the same cycle
`timescale 1ns/10ps
module tcp_counter_model
  import tcp_pkg::*;
(
  input wire logic clk, // CPU clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic tick, // Timer clock enable
  input wire logic preload, // Load request from the unit
  output logic [15:0] count // Counter value
);
  localparam logic [15:0] RELOAD = 16'hfffc;
  logic [15:0] next_count;

  always_comb begin
    next_count = count;
    if (preload) begin
      next_count = RELOAD;
    end else if (tick) begin
      next_count = count + 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    count <= rst_n ? next_count : RELOAD;
  end
endmodule : tcp_counter_model

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the compare unit
// Assumes: Classic bus, ack one cycle after request
// Notes: Random register traffic plus hand-made timer cases
`timescale 1ns/10ps
module tb
  import tcp_pkg::*;
;
  logic clk, rst_n, cyc, stb, we, cap_in, ext_clk, cap_f1, cap_f2, ovf_f;
  logic mask, ack, tick, preload, cap_set, ovf_ie, pin1, oe1, irq, pin2, oe2;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [1:0] csel;
  logic [15:0] cnt, v, g;
  logic [7:0] rd, b;
  int error_cnt, n_compared, k;
  logic [4:0] offs[8] = '{TCP_OFF_CTRL_ONE, TCP_OFF_CTRL_TWO, TCP_OFF_STATUS,
    TCP_OFF_CMP1_HI, TCP_OFF_CMP1_LO, TCP_OFF_CMP2_HI, TCP_OFF_CMP2_LO, 5'h1c};
  logic [7:0] rstv[8] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00,
    8'h00};
  logic [15:0] gaps[4] = '{16'd4, 16'd2, 16'd8, 16'd10};

  tcp_compare_unit tcp_compare_unit_i (.clk(clk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .counter_value(cnt), .capture_input_one(cap_in), .ext_clk(ext_clk),
    .capture_flag_one(cap_f1), .capture_flag_two(cap_f2),
    .overflow_flag(ovf_f), .cpu_int_mask(mask), .timer_tick(tick),
    .clock_select(csel), .counter_preload(preload),
    .capture_one_set(cap_set), .overflow_irq_enable(ovf_ie),
    .capture_edge_one(), .capture_edge_two(),
    .compare_output_pin_one(pin1), .compare_pin_one_oe_n(oe1),
    .compare_output_pin_two(pin2), .compare_pin_two_oe_n(oe2),
    .timer_irq(irq));

  tcp_counter_model tcp_counter_model_i (.clk(clk), .rst_n(rst_n),
    .tick(tick), .preload(preload), .count(cnt));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // External clock well under a quarter of the CPU clock
  always #50 ext_clk = ~ext_clk;

  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string what, input logic [4:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(what, {8'h0, rd}, {8'h0, e});
  endtask : rdc

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc

  task automatic gap(output logic [15:0] n);
    n = 16'h0;
    do @(posedge clk); while (tick !== 1'b1);
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1);
  endtask : gap

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    $display("FAIL timeout expected done seen hang");
    finish_test();
  end

  initial begin
    {rst_n, cyc, stb, we, cap_in, cap_f1, cap_f2, ovf_f, mask} = 9'h0;
    {ext_clk, adr, sel, wdat} = {1'b0, 5'h0, 4'h1, 32'h0};
    error_cnt = 0;
    n_compared = 0;
    void'($urandom(32'hc5c4c8b3));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (offs[i]) rdc("reset value", offs[i], rstv[i]);
    $display("test reset values done");
    repeat (4) begin
      v = 16'($urandom);
      wr(TCP_OFF_CMP2_HI, v[15:8]);
      wr(TCP_OFF_CMP2_LO, v[7:0]);
      rdc("cmp2 high", TCP_OFF_CMP2_HI, v[15:8]);
      rdc("cmp2 low", TCP_OFF_CMP2_LO, v[7:0]);
      b = 8'($urandom) & 8'he7;
      wr(TCP_OFF_CTRL_ONE, b);
      rdc("ctrl1", TCP_OFF_CTRL_ONE, b);
      chk("ovf enable", ovf_ie, b[5]);
    end
    wr(5'h1c, 8'h5a);
    rdc("unmapped", 5'h1c, 8'h00);
    wr(TCP_OFF_CTRL_ONE, 8'h00);
    $display("test register access done");
    foreach (gaps[i]) begin
      wr(TCP_OFF_CTRL_TWO, {4'h0, i[1:0], 2'b01});
      wait_cyc(1);
      chk("clock select", csel, i[1:0]);
      gap(g);
      gap(g);
      chk("tick spacing", g, gaps[i]);
    end
    $display("test clock select done");
    wr(TCP_OFF_CTRL_TWO, 8'h84);
    xfer(1'b0, TCP_OFF_STATUS, 8'h00);
    xfer(1'b0, TCP_OFF_CMP1_LO, 8'h00);
    wr(TCP_OFF_CTRL_ONE, 8'h41);
    chk("pin one enable", oe1, 1'b0);
    v = cnt + 16'd40;
    wr(TCP_OFF_CMP1_LO, v[7:0]);
    wr(TCP_OFF_CMP1_HI, v[15:8]);
    wait_cyc(120);
    xfer(1'b0, TCP_OFF_STATUS, 8'h00);
    chk("suspended flag", rd[6], 1'b0);
    chk("pin held low", pin1, 1'b0);
    v = cnt + 16'd30;
    wr(TCP_OFF_CMP1_HI, v[15:8]);
    xfer(1'b0, TCP_OFF_STATUS, 8'h00);
    wr(TCP_OFF_CMP1_LO, v[7:0]);
    for (k = 0; k < 200 && pin1 !== 1'b1; k++) @(posedge clk);
    wait_cyc(2);
    chk("pin one level", pin1, 1'b1);
    chk("compare irq", irq, 1'b1);
    mask <= 1'b1;
    wait_cyc(3);
    chk("irq masked", irq, 1'b0);
    mask <= 1'b0;
    xfer(1'b0, TCP_OFF_STATUS, 8'h00);
    chk("flag one set", rd[6], 1'b1);
    xfer(1'b0, TCP_OFF_CMP1_LO, 8'h00);
    xfer(1'b0, TCP_OFF_STATUS, 8'h00);
    chk("flag one cleared", rd[6], 1'b0);
    $display("test compare match done");
    wr(TCP_OFF_CTRL_ONE, 8'h08);
    wait_cyc(3);
    chk("forced low", pin1, 1'b0);
    wr(TCP_OFF_CTRL_ONE, 8'h09);
    wait_cyc(3);
    chk("forced high", pin1, 1'b1);
    xfer(1'b0, TCP_OFF_STATUS, 8'h00);
    chk("forced flag", rd[6], 1'b0);
    wr(TCP_OFF_CTRL_ONE, 8'h80);
    cap_f2 <= 1'b1;
    wait_cyc(3);
    chk("capture irq", irq, 1'b1);
    cap_f2 <= 1'b0;
    wait_cyc(3);
    chk("irq idle", irq, 1'b0);
    $display("test forced and capture done");
    xfer(1'b0, TCP_OFF_STATUS, 8'h00);
    xfer(1'b0, TCP_OFF_CMP2_LO, 8'h00);
    wr(TCP_OFF_CTRL_ONE, 8'h08);
    wr(TCP_OFF_CTRL_ONE, 8'h04);
    wr(TCP_OFF_CTRL_TWO, 8'hb4);
    v = cnt + 16'd30;
    wr(TCP_OFF_CMP2_HI, v[15:8]);
    wr(TCP_OFF_CMP2_LO, v[7:0]);
    for (k = 0; k < 200 && preload !== 1'b1; k++) @(posedge clk);
    chk("period capture", cap_set, 1'b1);
    wait_cyc(2);
    chk("pwm pin", pin1, 1'b1);
    xfer(1'b0, TCP_OFF_STATUS, 8'h00);
    chk("pwm flags", {rd[6], rd[3]}, 2'b00);
    $display("test pulse width done");
    wr(TCP_OFF_CTRL_TWO, 8'h40);
    v = cnt + 16'd20;
    wr(TCP_OFF_CMP2_HI, v[15:8]);
    wr(TCP_OFF_CMP2_LO, v[7:0]);
    for (k = 0; k < 200 && pin2 !== 1'b1; k++) @(posedge clk);
    chk("pin two enable", oe2, 1'b0);
    chk("plus one match", cnt, v + 16'd2);
    $display("test divided match done");
    wr(TCP_OFF_CTRL_ONE, 8'h08);
    wr(TCP_OFF_CTRL_ONE, 8'h04);
    wr(TCP_OFF_CTRL_TWO, 8'ha4);
    wr(TCP_OFF_CMP1_HI, 8'h00);
    xfer(1'b0, TCP_OFF_STATUS, 8'h00);
    wr(TCP_OFF_CMP1_LO, 8'h10);
    cap_in <= 1'b1;
    wait_cyc(4);
    cap_in <= 1'b0;
    for (k = 0; k < 20 && pin1 !== 1'b1; k++) @(posedge clk);
    chk("pulse preload", cnt, 16'hfffc);
    for (k = 0; k < 100 && pin1 !== 1'b0; k++) @(posedge clk);
    chk("pulse end", cnt, 16'h0011);
    xfer(1'b0, TCP_OFF_STATUS, 8'h00);
    chk("pulse flag one", rd[6], 1'b0);
    $display("test one pulse done");
    finish_test();
  end
endmodule : tb
